/* File: rtl/slo_bank.sv */
// Top of the serdes level status and override register bank with APB slave.
// Overview of operation.
// The bank answers every APB transfer in its first access cycle, so pready is
// tied high and pslverr is tied low; no transfer is ever stretched or refused.
// The status word is a live view of the synchronised level control inputs.
// It keeps showing those inputs while the override is on, so software must
// read the override word to learn which codes the transceiver really uses.
// The override word is plain storage; its enable bit switches all three level
// codes at once, which keeps the transceiver from ever seeing a mixed set.
// The level outputs are registered, so a write to the override word reaches
// the transceiver one clock after the write has been taken.
// The level control inputs are asynchronous and pass a two-flop synchroniser
// before any logic reads them; codes that change in mid-transfer may be seen
// two clocks late, which is harmless for slowly moving analogue settings.
// Bits 15:0 of the override word have no function in this block; they are
// kept only so that a read-modify-write by software returns what it stored.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module slo_bank
    import slo_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire slo_levels_t level_ctl_in,
    output slo_levels_t      level_out,
    output logic             level_override_active
);

    // Synchronised control inputs.
    slo_levels_t ctl_sync;
    // Override word state.
    logic        level_override_enable_ff;
    slo_levels_t ovr_levels_ff;
    logic [15:0] preserved_spare_bits_ff;
    // Read data register and its next value.
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    // Access-phase strobes.
    logic        acc_wr;
    logic        acc_rd;
    // Decoded register selects, shared by the write and read paths.
    logic        sel_ovr;
    logic        sel_stat;

    // True when the address selects the given register word.
    // Only the low twelve address bits reach the bank, so the decode is a
    // plain compare; any other offset falls through as unmapped.
    function automatic logic slo_hit(input logic [11:0] addr, input logic [11:0] ofs);
        slo_hit = (addr == ofs);
    endfunction

    // Pack a level triple into its register field position.
    function automatic logic [31:0] slo_pack(input logic top, input slo_levels_t l, input logic [15:0] lo);
        slo_pack = {top, l.tx_swing, l.signal_loss_threshold, l.ac_scan_comparator_threshold, lo};
    endfunction

    // Control inputs come from outside the clock domain.
    slo_sync u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (level_ctl_in),
        .sync_out (ctl_sync)
    );

    // Zero wait states: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign acc_wr  = psel && penable && pwrite;
    assign acc_rd  = psel && penable && !pwrite;
    // The same decode serves the write path and the read mux.
    assign sel_ovr  = slo_hit(paddr, SLO_OVERRIDE_OFS);
    assign sel_stat = slo_hit(paddr, SLO_STATUS_OFS);

    // Override word storage; byte lanes honoured through pstrb.
    // A write takes effect only at the edge that closes the access phase.
    // Writes to the status word or to an unmapped offset change nothing here.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // The enable starts cleared so the inputs drive the levels.
            level_override_enable_ff <= 1'b0;
            ovr_levels_ff            <= {SLO_OVR_LVL_RST, SLO_OVR_LVL_RST, SLO_OVR_LVL_RST};
            preserved_spare_bits_ff  <= SLO_SPARE_RST;
        end
        else if (acc_wr && sel_ovr)
        begin
            // Byte 3 holds the enable, the whole swing code and the top of the loss code.
            if (pstrb[3])
            begin
                level_override_enable_ff <= pwdata[SLO_EN_BIT];
                ovr_levels_ff.tx_swing   <= pwdata[SLO_TX_LSB +: SLO_LVL_W];
                ovr_levels_ff.signal_loss_threshold[4:3] <= pwdata[SLO_LOS_LSB+3 +: 2];
            end
            // Byte 2 holds the rest of the loss code and the comparator code.
            if (pstrb[2])
            begin
                ovr_levels_ff.signal_loss_threshold[2:0] <= pwdata[SLO_LOS_LSB +: 3];
                ovr_levels_ff.ac_scan_comparator_threshold <= pwdata[SLO_SCAN_LSB +: SLO_LVL_W];
            end
            // Spare bits are plain storage, software writes back what it read.
            if (pstrb[1])
            begin
                preserved_spare_bits_ff[15:8] <= pwdata[15:8];
            end
            if (pstrb[0])
            begin
                preserved_spare_bits_ff[7:0] <= pwdata[7:0];
            end
        end
    end

    // Level output mux, registered so a write shows on the next cycle.
    // Registering the mux also keeps glitches off the analogue controls when
    // the enable and the codes change in the same write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_out             <= '0;
            level_override_active <= 1'b0;
        end
        else
        begin
            // The active flag moves with the outputs so the two always agree.
            level_override_active <= level_override_enable_ff;
            // All three codes switch together.
            if (level_override_enable_ff)
            begin
                level_out <= ovr_levels_ff;
            end
            else
            begin
                // Without override the synchronised inputs pass straight on.
                level_out <= ctl_sync;
            end
        end
    end

    // Read mux; status mirrors inputs, not the override, so it goes stale under override.
    always_comb
    begin
        nxt_prdata = prdata_ff;
        if (acc_rd)
        begin
            if (sel_stat)
            begin
                // Reserved status bits read as ones around the live codes.
                nxt_prdata = slo_pack(SLO_STAT_RSVD_HI, ctl_sync, SLO_STAT_RSVD_LO);
            end
            else if (sel_ovr)
            begin
                // The override word reads back exactly what was stored.
                nxt_prdata = slo_pack(level_override_enable_ff, ovr_levels_ff, preserved_spare_bits_ff);
            end
            else
            begin
                // Unmapped offsets read as zero and raise no error.
                nxt_prdata = SLO_UNMAPPED_DATA;
            end
        end
    end

    // Read data register; writes to the status word fall through with no effect.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= '0;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Read data is combinational from live state during the access phase.
    // Outside a read the last word read stays on the bus, which keeps prdata
    // quiet between transfers.
    always_comb
    begin
        if (acc_rd)
        begin
            prdata = nxt_prdata;
        end
        else
        begin
            prdata = prdata_ff;
        end
    end

endmodule // slo_bank
`default_nettype wire

/* File: rtl/slo_pkg.sv */
// Package with register map, field layout and reset values of the level override bank.
package slo_pkg;

    // Byte addresses of the two registers.
    localparam logic [11:0] SLO_STATUS_OFS   = 12'h420;
    localparam logic [11:0] SLO_OVERRIDE_OFS = 12'h428;

    // Field positions shared by both registers.
    localparam int SLO_EN_BIT    = 31;
    localparam int SLO_TX_LSB    = 26;
    localparam int SLO_LOS_LSB   = 21;
    localparam int SLO_SCAN_LSB  = 16;
    localparam int SLO_LVL_W     = 5;
    localparam int SLO_SPARE_W   = 16;

    // Reset and read values.
    localparam logic [4:0]  SLO_OVR_LVL_RST   = 5'h10;
    localparam logic [15:0] SLO_SPARE_RST     = 16'h0000;
    localparam logic        SLO_STAT_RSVD_HI  = 1'h1;
    localparam logic [15:0] SLO_STAT_RSVD_LO  = 16'hffff;
    localparam logic [31:0] SLO_UNMAPPED_DATA = 32'h0000_0000;

    // The three level codes travel together as one carrier.
    typedef struct packed
    {
        logic [4:0] tx_swing;
        logic [4:0] signal_loss_threshold;
        logic [4:0] ac_scan_comparator_threshold;
    } slo_levels_t;

endpackage : slo_pkg

/* File: rtl/slo_sync.sv */
// Two-flop synchroniser for the level control inputs.
`timescale 1ns/1ps
`default_nettype none
module slo_sync
    import slo_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire slo_levels_t async_in,
    output slo_levels_t      sync_out
);

    // First stage; only the second stage reads it.
    slo_levels_t meta_ff;

    // Two-stage capture; resets to zero, settles to the inputs two edges after release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff  <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule // slo_sync
`default_nettype wire

/* File: sim/slo_bank_asserts.sv */
// Concurrent checks on the ports of the level override bank.
`timescale 1ns/1ps
`default_nettype none
module slo_bank_asserts
    import slo_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire slo_levels_t level_ctl_in,
    input wire slo_levels_t level_out,
    input wire logic        level_override_active
);
    // Decoded transfers taken at this edge.
    wire acc    = psel && penable;
    wire wr_ovr = acc && pwrite && paddr == SLO_OVERRIDE_OFS;
    wire wr_st  = acc && pwrite && paddr == SLO_STATUS_OFS;
    wire rd_st  = acc && !pwrite && paddr == SLO_STATUS_OFS;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rst; $rose(presetn) |-> !level_override_active; endproperty
    a_rst: assert property (p_rst) else $error("enable set after reset");
    property p_en; logic d; (wr_ovr && pstrb[3], d = pwdata[31]) |=> ##1 level_override_active == d; endproperty
    a_en: assert property (p_en) else $error("enable not taken");
    property p_ovr; logic [14:0] c; (wr_ovr && pstrb == 4'hf && pwdata[31], c = pwdata[30:16]) |=> ##1 level_out == c;
    endproperty
    a_ovr: assert property (p_ovr) else $error("codes not driven");
    property p_hold; !wr_ovr ##1 level_override_active |=> $stable(level_out); endproperty
    a_hold: assert property (p_hold) else $error("override levels moved");
    property p_in; ($stable(level_ctl_in) && !level_override_active)[*4] |-> level_out == level_ctl_in; endproperty
    a_in: assert property (p_in) else $error("levels not from inputs");
    property p_strd; $stable(level_ctl_in)[*3] ##0 rd_st |-> prdata == {1'b1, level_ctl_in, 16'hffff}; endproperty
    a_strd: assert property (p_strd) else $error("bad status word");
    property p_stwr; wr_st ##1 level_override_active |=> $stable(level_out); endproperty
    a_stwr: assert property (p_stwr) else $error("status write acted");
    property p_resp; psel |-> pready && !pslverr; endproperty
    a_resp: assert property (p_resp) else $error("bad response");
endmodule // slo_bank_asserts
`default_nettype wire

/* File: sim/slo_bank_test.sv */
// Self-checking bench for the level override bank.
`timescale 1ns/1ps
`default_nettype none
module slo_bank_test
    import slo_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, level_override_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    slo_levels_t level_ctl_in, level_out;
    int          mismatches = 0;
    int          compares = 0;
    slo_bank i_dut (.*);
    // Clock of 10 ns period.
    always #5 pclk = ~pclk;
    // Holds reset for 20 cycles, then releases it.
    task automatic rst;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // One APB transfer and an idle cycle; read data lands in rd.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic rdy;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Samples the settled answer mid-cycle, then takes the edge it belongs to.
        do
        begin
            @(negedge pclk);
            rd = prdata;
            rdy = pready;
            @(posedge pclk);
        end
        while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Compares one value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic summarize;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cuts a hang short.
    initial
    begin
        #20us;
        mismatches++;
        summarize();
    end
    // Main sequence of register accesses.
    initial
    begin
        {pclk, presetn, psel, penable, pwrite} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        level_ctl_in = 15'h4240;
        rst();
        repeat (3) @(posedge pclk);
        apb(1'b0, SLO_STATUS_OFS, 32'h0, 4'h0);
        chk(rd, 32'hc240_ffff);
        chk(32'(level_out), 32'h4240);
        apb(1'b0, SLO_OVERRIDE_OFS, 32'h0, 4'h0);
        chk(rd, 32'h4210_0000);
        apb(1'b1, SLO_OVERRIDE_OFS, 32'hfc35_a5c3, 4'hf);
        level_ctl_in <= 15'h0c55;
        apb(1'b1, SLO_STATUS_OFS, 32'hffff_ffff, 4'hf);
        apb(1'b0, SLO_OVERRIDE_OFS, 32'h0, 4'h0);
        chk(rd, 32'hfc35_a5c3);
        chk(32'(level_out), 32'h7c35);
        chk(32'(level_override_active), 32'h1);
        apb(1'b0, SLO_STATUS_OFS, 32'h0, 4'h0);
        chk(rd, 32'h8c55_ffff);
        apb(1'b1, SLO_OVERRIDE_OFS, 32'h0, 4'h3);
        apb(1'b0, SLO_OVERRIDE_OFS, 32'h0, 4'h0);
        chk(rd, 32'hfc35_0000);
        apb(1'b1, SLO_OVERRIDE_OFS, 32'h0, 4'hf);
        apb(1'b0, 12'h424, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk(32'(level_out), 32'h0c55);
        rst();
        apb(1'b0, SLO_OVERRIDE_OFS, 32'h0, 4'h0);
        chk(rd, 32'h4210_0000);
        summarize();
    end
endmodule // slo_bank_test
bind slo_bank slo_bank_asserts i_chk (.*);
`default_nettype wire
